// [src/status_flags.sv]
/*
 * Processor status flag register with flag update logic, bcd correction
 * and branch condition evaluation, plus an Avalon-MM register slave.
 * Assumes the sequencer presents one operation per cycle, single mclk domain.
 */
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module status_flags
    import flags_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    // operation from the sequencer
    input  wire logic [3:0]  opClass,
    input  wire logic [7:0]  operandA,
    input  wire logic [7:0]  operandB,
    input  wire logic [7:0]  rotResult,
    input  wire logic        rotCarryOut,
    input  wire logic        rotOverflow,
    input  wire logic [7:0]  stackFlags,
    input  wire logic        cpuFlagWrite,
    input  wire logic [7:0]  cpuFlagData,
    output logic [7:0]       aluResult,
    // branch decision
    input  wire logic [7:0]  branchOpcode,
    output logic             branchTaken,
    // status word
    output logic [7:0]       flags,
    // Avalon-MM slave
    input  wire logic [7:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWritedata,
    input  wire logic [3:0]  avsByteenable,
    output logic [31:0]      avsReaddata,
    output logic             avsWaitrequest,
    output logic [1:0]       avsResponse
);

    // ------------------------------------------------------------
    // condition decode
    // ------------------------------------------------------------
    // only carry/zero/sign/overflow enter; decimal and half never do
    function automatic logic condTrue(input logic [3:0] condField, input logic c,
                                      input logic z, input logic s,
                                      input logic v);
        logic below;
        below = s ^ v;
        case (condField)
            COND_NEVER:            condTrue = 1'b0;
            COND_ALWAYS:           condTrue = 1'b1;
            COND_CARRY:            condTrue = c;
            COND_NO_CARRY:         condTrue = ~c;
            COND_ZERO:             condTrue = z;
            COND_NONZERO:          condTrue = ~z;
            COND_MINUS:            condTrue = s;
            COND_PLUS:             condTrue = ~s;
            COND_OVERFLOW:         condTrue = v;
            COND_NO_OVERFLOW:      condTrue = ~v;
            COND_SIGNED_AT_LEAST:  condTrue = ~below;
            COND_SIGNED_BELOW:     condTrue = below;
            COND_SIGNED_ABOVE:     condTrue = ~(z | below);
            COND_SIGNED_AT_MOST:   condTrue = z | below;
            COND_UNSIGNED_ABOVE:   condTrue = ~c & ~z;
            COND_UNSIGNED_AT_MOST: condTrue = c | z;
            default:               condTrue = 1'b0;
        endcase
    endfunction

    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic       busHit;
    logic       busWriteHit;
    logic       readPending_q;
    logic [8:0] sum9;
    logic [4:0] low5;
    logic [7:0] bcdFix;
    logic       bcdCarry;
    logic [7:0] result;

    // ------------------------------------------------------------
    // arithmetic datapath
    // ------------------------------------------------------------
    // add and subtract use separate expressions; SBC takes the carry flag in as borrow
    always_comb begin
        logic cin;
        logic isSub;
        cin      = 1'b0;
        isSub    = (opClass == OP_SUB) || (opClass == OP_SBC);
        if (opClass == OP_ADC) begin
            cin = flags_q[CARRY_BIT];
        end else if (opClass == OP_SBC) begin
            cin = flags_q[CARRY_BIT];
        end
        if (isSub) begin
            sum9 = {1'b0, operandA} - {1'b0, operandB} - {8'h00, cin};
            low5 = {1'b0, operandA[3:0]} - {1'b0, operandB[3:0]} - {4'h0, cin};
        end else begin
            sum9 = {1'b0, operandA} + {1'b0, operandB} + {8'h00, cin};
            low5 = {1'b0, operandA[3:0]} + {1'b0, operandB[3:0]} + {4'h0, cin};
        end
    end

    // bcd correction driven by carry, half carry and decimal flag
    always_comb begin
        bcdFix   = 8'h00;
        bcdCarry = flags_q[CARRY_BIT];
        if (flags_q[HALF_BIT] || (!flags_q[DECIMAL_BIT] && operandA[3:0] > 4'h9)) begin
            bcdFix[3:0] = 4'h6;
        end
        if (flags_q[CARRY_BIT] || (!flags_q[DECIMAL_BIT] && operandA > 8'h99)) begin
            bcdFix[7:4] = 4'h6;
            bcdCarry    = 1'b1;
        end
    end

    // result byte picked per class
    always_comb begin
        case (opClass)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: result = sum9[7:0];
            OP_BCD:      result = flags_q[DECIMAL_BIT] ? operandA - bcdFix
                                                       : operandA + bcdFix;
            OP_ROTSHIFT: result = rotResult;
            OP_INCDEC:   result = operandA;
            default:     result = operandA;   // logic/bit-test result given in operandA
        endcase
    end

    // ------------------------------------------------------------
    // flag update
    // ------------------------------------------------------------
    always_comb begin
        logic addOv;
        logic subOv;
        flags_d = flags_q;
        addOv   = (operandA[7] == operandB[7]) && (sum9[7] != operandA[7]);
        subOv   = (operandA[7] != operandB[7]) && (sum9[7] != operandA[7]);
        case (opClass)
            OP_ADD, OP_ADC: begin
                flags_d[CARRY_BIT]    = sum9[8];
                flags_d[OVERFLOW_BIT] = addOv;
                flags_d[DECIMAL_BIT]  = 1'b0;
                flags_d[HALF_BIT]     = low5[4];
            end
            OP_SUB, OP_SBC: begin
                flags_d[CARRY_BIT]    = sum9[8];
                flags_d[OVERFLOW_BIT] = subOv;
                flags_d[DECIMAL_BIT]  = 1'b1;
                flags_d[HALF_BIT]     = low5[4];
            end
            OP_LOGIC, OP_BITTEST: begin
                flags_d[OVERFLOW_BIT] = 1'b0;
            end
            OP_ROTSHIFT: begin
                flags_d[CARRY_BIT]    = rotCarryOut;
                flags_d[OVERFLOW_BIT] = rotOverflow;
            end
            OP_BCD: begin
                flags_d[CARRY_BIT] = bcdCarry;
            end
            OP_SETC: flags_d[CARRY_BIT] = 1'b1;
            OP_CLRC: flags_d[CARRY_BIT] = 1'b0;
            OP_CPLC: flags_d[CARRY_BIT] = ~flags_q[CARRY_BIT];
            OP_WATCHDOG: begin
                flags_d[ZERO_BIT]     = 1'b1;
                flags_d[SIGN_BIT]     = 1'b0;
                flags_d[OVERFLOW_BIT] = 1'b0;
            end
            OP_INT_RETURN: flags_d = stackFlags;
            default: flags_d = flags_q;
        endcase
        // zero and sign follow the result byte for result-producing classes except OP_INCDEC
        if (opClass inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_LOGIC,
                            OP_BITTEST, OP_ROTSHIFT, OP_BCD}) begin
            flags_d[ZERO_BIT] = (result == 8'h00);
            flags_d[SIGN_BIT] = result[7];
        end
        // user bits only move on explicit writes (interrupt return restores the stacked byte)
        if (opClass != OP_INT_RETURN) begin
            flags_d[USER_TWO_BIT] = flags_q[USER_TWO_BIT];
            flags_d[USER_ONE_BIT] = flags_q[USER_ONE_BIT];
        end
        // explicit writes win over the instruction's own update
        if (busWriteHit) begin
            flags_d = avsWritedata[7:0];
        end else if (cpuFlagWrite) begin
            flags_d = cpuFlagData;
        end
    end

    // status register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flags_q <= STATUS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // registered result byte
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            aluResult <= 8'h00;
        end else begin
            aluResult <= result;
        end
    end

    // branch decision on live flags; condition in opcode high nibble
    assign branchTaken = condTrue(branchOpcode[COND_LSB +: 4], flags_q[CARRY_BIT],
                                  flags_q[ZERO_BIT], flags_q[SIGN_BIT],
                                  flags_q[OVERFLOW_BIT]);
    assign flags = flags_q;

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    // writes complete at once; reads take one wait cycle so data is registered
    assign busHit      = (avsAddress == STATUS_OFFSET);
    assign busWriteHit = avsWrite && busHit && avsByteenable[0];
    assign avsWaitrequest = avsRead && !readPending_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            readPending_q <= 1'b0;
            avsReaddata   <= 32'h0000_0000;
            avsResponse   <= 2'h0;
        end else begin
            readPending_q <= avsRead && !readPending_q;
            if (avsRead && !readPending_q) begin
                avsReaddata <= busHit ? {24'h000000, flags_q} : 32'h0000_0000;
                avsResponse <= busHit ? 2'h0 : 2'h2;     // slave error on unmapped
            end else if (avsWrite) begin
                avsResponse <= busHit ? 2'h0 : 2'h2;
            end
        end
    end

endmodule // status_flags

`default_nettype wire

// [shared/flags_pkg.sv]
/*
 * Constants for the processor status flag block: register offset, bit
 * positions, reset value, operation classes and branch condition codes.
 * Assumes the block sits behind an Avalon-MM slave with 32-bit data.
 */
package flags_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_OFFSET = 8'hFC;   // word address byte offset
    localparam logic [7:0] STATUS_RESET  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CARRY_BIT    = 7;
    localparam int ZERO_BIT     = 6;
    localparam int SIGN_BIT     = 5;
    localparam int OVERFLOW_BIT = 4;
    localparam int DECIMAL_BIT  = 3;
    localparam int HALF_BIT     = 2;
    localparam int USER_TWO_BIT = 1;
    localparam int USER_ONE_BIT = 0;
    localparam int COND_LSB     = 4;

    // ------------------------------------------------------------
    // operation classes from the sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_ADD      = 4'h1,
        OP_ADC      = 4'h2,
        OP_SUB      = 4'h3,
        OP_SBC      = 4'h4,
        OP_LOGIC    = 4'h5,
        OP_BITTEST  = 4'h6,
        OP_ROTSHIFT = 4'h7,
        OP_SETC     = 4'h8,
        OP_CLRC     = 4'h9,
        OP_CPLC     = 4'hA,
        OP_WATCHDOG = 4'hB,
        OP_INT_RETURN = 4'hC,
        OP_BCD      = 4'hD,
        OP_INCDEC   = 4'hE
    } flag_op_e;

    // ------------------------------------------------------------
    // branch condition codes
    // ------------------------------------------------------------
    localparam logic [3:0] COND_NEVER            = 4'h0;
    localparam logic [3:0] COND_SIGNED_BELOW     = 4'h1;
    localparam logic [3:0] COND_SIGNED_AT_MOST   = 4'h2;
    localparam logic [3:0] COND_UNSIGNED_AT_MOST = 4'h3;
    localparam logic [3:0] COND_OVERFLOW         = 4'h4;
    localparam logic [3:0] COND_MINUS            = 4'h5;
    localparam logic [3:0] COND_ZERO             = 4'h6;
    localparam logic [3:0] COND_CARRY            = 4'h7;
    localparam logic [3:0] COND_ALWAYS           = 4'h8;
    localparam logic [3:0] COND_SIGNED_AT_LEAST  = 4'h9;
    localparam logic [3:0] COND_SIGNED_ABOVE     = 4'hA;
    localparam logic [3:0] COND_UNSIGNED_ABOVE   = 4'hB;
    localparam logic [3:0] COND_NO_OVERFLOW      = 4'hC;
    localparam logic [3:0] COND_PLUS             = 4'hD;
    localparam logic [3:0] COND_NONZERO          = 4'hE;
    localparam logic [3:0] COND_NO_CARRY         = 4'hF;

endpackage

// [tb/status_flags_sva.sv]
/* Checker for the status flag block, watching only its ports.
   Assumes one mclk domain and resetn asynchronous, active low. */
`timescale 1ns/1ns
`default_nettype none
module status_flags_sva
    import flags_pkg::*;
(
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic [3:0] opClass,
    input wire logic [7:0] operandA,
    input wire logic [7:0] rotResult,
    input wire logic       rotCarryOut,
    input wire logic [7:0] stackFlags,
    input wire logic       cpuFlagWrite,
    input wire logic [7:0] cpuFlagData,
    input wire logic [7:0] branchOpcode,
    input wire logic       branchTaken,
    input wire logic [7:0] flags,
    input wire logic [7:0] avsAddress,
    input wire logic       avsWrite,
    input wire logic [3:0] avsByteenable
);
    // ------------------------------------------------------------
    // qualifiers
    // ------------------------------------------------------------
    // a bus write outranks every other source, so it gates the antecedents
    logic busWr;
    logic quiet;
    logic [3:0] condField;
    assign busWr     = avsWrite && avsAddress == STATUS_OFFSET && avsByteenable[0];
    assign quiet     = !busWr && !cpuFlagWrite;
    assign condField = branchOpcode[7:4];
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // flag updates
    // ------------------------------------------------------------
    wdog_flags_a: assert property (
        quiet && opClass == OP_WATCHDOG |=> flags[6:4] == 3'b100) else $error("watchdog flags");
    stack_restore_a: assert property (
        quiet && opClass == OP_INT_RETURN |=> flags[7:2] == $past(stackFlags[7:2]))
        else $error("stack restore");
    rot_flags_a: assert property (
        quiet && opClass == OP_ROTSHIFT |=> flags[7] == $past(rotCarryOut)
        && flags[6] == ($past(rotResult) == 8'h00)) else $error("rotate flags");
    logic_flags_a: assert property (
        quiet && opClass == OP_LOGIC |=> !flags[4] && flags[6] == ($past(operandA) == 8'h00)
        && flags[5] == $past(operandA[7])) else $error("logic flags");
    carry_ops_a: assert property (
        quiet && opClass inside {OP_SETC, OP_CLRC, OP_CPLC} |=> flags[7] ==
        ($past(opClass) == OP_SETC || ($past(opClass) == OP_CPLC && !$past(flags[7]))))
        else $error("carry op");
    user_bits_a: assert property (
        quiet && opClass != OP_INT_RETURN |=> $stable(flags[1:0])) else $error("user bits moved");
    write_wins_a: assert property (
        !busWr && cpuFlagWrite |=> flags == $past(cpuFlagData)) else $error("flag write");
    // ------------------------------------------------------------
    // branch decisions
    // ------------------------------------------------------------
    simple_cond_a: assert property (
        (condField == COND_NEVER |-> !branchTaken) and (condField == COND_ALWAYS |-> branchTaken)
        and (condField == COND_CARRY |-> branchTaken == flags[7])) else $error("simple cond");
    signed_cond_a: assert property (
        condField == COND_SIGNED_BELOW |-> branchTaken == (flags[5] ^ flags[4]))
        else $error("signed cond");
    unsigned_cond_a: assert property (
        condField == COND_UNSIGNED_ABOVE |-> branchTaken == !(flags[7] | flags[6]))
        else $error("unsigned cond");
    cover property (quiet && opClass == OP_INT_RETURN);
    cover property (cpuFlagWrite && opClass != OP_NONE);
    cover property (busWr);
endmodule // status_flags_sva
`default_nettype wire

// [tb/rot_partner.sv]
/* Partner model: the rotate unit beside the flag block.
   Assumes operandA is the byte rotated left, one per cycle. */
`timescale 1ns/1ns
`default_nettype none
module rot_partner (
    input wire logic [7:0] operandA,
    output logic [7:0]     rotResult,
    output logic           rotCarryOut,
    output logic           rotOverflow
);
    // ------------------------------------------------------------
    // rotate left
    // ------------------------------------------------------------
    // combinational, so it answers in the same cycle as the operand
    assign rotResult   = {operandA[6:0], operandA[7]};
    assign rotCarryOut = operandA[7];
    assign rotOverflow = operandA[7] ^ operandA[6]; // sign change
endmodule // rot_partner
`default_nettype wire

// [tb/status_flags_tb.sv]
/* Self-checking bench for the status flag block with a flag model.
   Assumes the rotate partner and the checker bound to the design. */
`timescale 1ns/1ns
`default_nettype none
module status_flags_tb;
    import flags_pkg::*;
    logic        mclk = 0, resetn = 0, rotCarryOut, rotOverflow, cpuFlagWrite = 0;
    logic        branchTaken, avsRead = 0, avsWrite = 0, avsWaitrequest;
    logic [3:0]  opClass = 0, avsByteenable = 0;
    logic [7:0]  operandA = 0, operandB = 0, rotResult, stackFlags = 0, cpuFlagData = 0;
    logic [7:0]  aluResult, branchOpcode = 0, flags, avsAddress = 0, em, mk, a, b, f0;
    logic [31:0] avsWritedata = 0, avsReaddata, rd, seed = 32'hCE5B;
    logic [1:0]  avsResponse, rsp;
    logic [3:0]  oc;
    int          num_errors = 0, num_checks = 0;
    status_flags i_status_flags (.mclk, .resetn, .opClass, .operandA, .operandB, .rotResult,
        .rotCarryOut, .rotOverflow, .stackFlags, .cpuFlagWrite, .cpuFlagData, .aluResult,
        .branchOpcode, .branchTaken, .flags, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
        .avsByteenable, .avsReaddata, .avsWaitrequest, .avsResponse);
    rot_partner i_rot_partner (.operandA, .rotResult, .rotCarryOut, .rotOverflow);
    // 10 MHz clock
    initial forever #50 mclk = ~mclk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h00000000);
    endfunction
    task report_and_stop;
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // one Avalon cycle; request held until the rising edge that sees waitrequest low,
    // read data and response taken at that edge, released right after it
    task bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, input logic [3:0] be);
        int n;
        @(posedge mclk);
        avsAddress <= ad;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= wd;
        avsByteenable <= be;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 50);
        rd = avsReaddata;
        rsp = avsResponse;
        avsRead <= 0;
        avsWrite <= 0;
        // a slave that never answers ends the run as a failure
        if (avsWaitrequest !== 1'b0) begin
            num_errors++;
            report_and_stop;
        end
    endtask
    // one operation cycle, flags looked at once it has landed
    task op(input logic [3:0] c, input logic [7:0] x, y, st, input logic fw, input logic [7:0] fd);
        @(posedge mclk);
        opClass <= c;
        operandA <= x;
        operandB <= y;
        stackFlags <= st;
        cpuFlagWrite <= fw;
        cpuFlagData <= fd;
        @(posedge mclk);
        opClass <= OP_NONE;
        cpuFlagWrite <= 0;
        @(negedge mclk);
    endtask
    // expected flags from the previous value em
    task model(input logic [3:0] c, input logic [7:0] x, y, st);
        logic [8:0] r;
        logic [4:0] h;
        logic       ci, s;
        ci = (c == OP_ADC || c == OP_SBC) && em[7];
        s = c == OP_SUB || c == OP_SBC;
        mk = 8'hFF;
        case (c)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                r = s ? {1'b0, x} - y - ci : x + y + ci;
                h = s ? {1'b0, x[3:0]} - y[3:0] - ci : x[3:0] + y[3:0] + ci;
                em[7:2] = {r[8], r[7:0] == 0, r[7], (x[7] ^ y[7] ^ !s) & (r[7] ^ x[7]), s, h[4]};
                check(aluResult, r[7:0], "sum");
            end
            OP_LOGIC: em[6:4] = {x == 0, x[7], 1'b0};
            OP_BITTEST: begin
                em[6] = x == 0;
                mk = 8'hCF; // sign and overflow left open for bit tests
            end
            OP_ROTSHIFT: em[7:4] = {x[7], x == 0, x[6], x[7] ^ x[6]};
            OP_SETC: em[7] = 1;
            OP_CLRC: em[7] = 0;
            OP_CPLC: em[7] = !em[7];
            OP_WATCHDOG: em[6:4] = 3'b100;
            OP_INT_RETURN: begin
                em = st;
                mk = 8'hFC;
            end
            default: ;
        endcase
    endtask
    function automatic logic br(input logic [3:0] c, input logic [7:0] f);
        logic t;
        case (c[2:0])
            0: t = 0;
            1: t = f[5] ^ f[4];
            2: t = f[6] | (f[5] ^ f[4]);
            3: t = f[7] | f[6];
            4: t = f[4];
            5: t = f[5];
            6: t = f[6];
            default: t = f[7];
        endcase
        return c[3] ? !t : t;
    endfunction
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        resetn <= 1;
        check(flags, STATUS_RESET, "reset flags");
        bus(1, STATUS_OFFSET, 32'h000000A5, 4'h1);
        bus(0, STATUS_OFFSET, 0, 4'hF);
        check(rd, 32'h000000A5, "status read");
        bus(1, STATUS_OFFSET, 32'h0000005A, 4'hE);
        bus(1, 8'hFB, 32'h0000005A, 4'hF);
        @(negedge mclk);
        check(32'(avsResponse), 32'h2, "unmapped write response");
        bus(0, 8'hFB, 0, 4'hF);
        check(rd, 32'h0, "unmapped read");
        check(32'(rsp), 32'h2, "unmapped read response");
        bus(0, STATUS_OFFSET, 0, 4'hF);
        check(rd, 32'hA5, "ignored write");
        check(32'(rsp), 32'h0, "mapped read response");
        for (int i = 0; i < 300; i++) begin
            seed = lfsr(seed);
            f0 = seed[7:0];
            a = seed[15:8];
            b = seed[23:16];
            oc = seed[27:24];
            op(OP_NONE, 0, 0, 0, 1, f0);
            em = f0;
            check(flags, f0, "explicit write");
            for (int c = 0; c < 16; c++) begin
                @(posedge mclk);
                branchOpcode <= {c[3:0], seed[31:28]};
                @(negedge mclk);
                check(branchTaken, br(c[3:0], f0), "branch");
            end
            if (oc == OP_BCD || oc == 4'hF) oc = OP_NONE;
            op(oc, a, b, ~f0, i % 8 == 0, ~a);
            model(oc, a, b, ~f0);
            if (i % 8 == 0) em = ~a;
            check(flags & mk, em & mk, "flags");
        end
        op(OP_ADD, 8'h15, 8'h27, 0, 0, 0);
        op(OP_BCD, 8'h3C, 0, 0, 0, 0);
        check(aluResult, 8'h42, "bcd");
        report_and_stop;
    end
endmodule // status_flags_tb
bind status_flags status_flags_sva i_status_flags_sva (.mclk, .resetn, .opClass, .operandA,
    .rotResult, .rotCarryOut, .stackFlags, .cpuFlagWrite, .cpuFlagData, .branchOpcode,
    .branchTaken, .flags, .avsAddress, .avsWrite, .avsByteenable);
`default_nettype wire
